// ==== hdl/host_port_channel.sv ====
// One host port channel: outbound byte, inbound byte and status flags
`default_nettype none
// Contract
// R1 - Drive outbound byte only with select, address and read strobe all low.
// R2 - Outbound byte is 8 bits, slave read/write, host read-only, no reset; here the slave can only write it, not read it back.
// R3 - Status bits 7..4 and 2 are user bits, slave writable, reset zero.
// R4 - Status bit 3 holds address line level of last host inbound write.
// R5 - Command flag follows address line on host write strobe rising edge.
// R6 - Input-full set by host write rising edge, cleared by slave read fall.
// R7 - Input-full is an interrupt source to the slave, read-only everywhere.
// R8 - Output-full set on slave write fall, cleared on host read rising edge.
// R9 - Slave clears output-full by writing zero; writing one does nothing.
// R10 - Fast gate mode uses different input-full set and clear conditions; here only the set condition changes, and the clear stays the slave read fall.
// R11 - Host write rising edge with select low captures data and address line.
// R12 - Input-full interrupt request is gated by a per-channel enable bit.
// R13 - Host read with address line high returns the status register.
module host_port_channel
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  resetn_i,
  // Host parallel bus
  input  wire logic                  channel_select_n_i,
  input  wire logic                  host_address_line_i,
  input  wire logic                  host_read_strobe_n_i,
  input  wire logic                  host_write_strobe_n_i,
  input  wire logic [DATA_WIDTH-1:0] host_data_i,
  output logic      [DATA_WIDTH-1:0] host_data_o,
  output logic                       host_data_oe_o,
  // Slave CPU register port
  input  wire logic                  slave_select_i,
  input  wire logic                  slave_read_i,
  input  wire logic                  slave_write_i,
  input  wire logic [DATA_WIDTH-1:0] slave_wdata_i,
  output logic      [DATA_WIDTH-1:0] slave_rdata_o,
  // Mode and interrupt
  input  wire logic                  fast_a20_enable_i,
  input  wire logic                  input_full_irq_enable_i,
  output logic                       input_full_irq_o
);

  function automatic logic rise(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  function automatic logic fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  // Previous-cycle samples; strobe edges are seen at the first clock after the pin changes
  logic                  cs_n_q;
  logic                  addr_q;
  logic                  rd_n_q;
  logic                  wr_n_q;
  logic [DATA_WIDTH-1:0] hdata_q;
  logic                  ssel_q;
  logic                  srd_q;
  logic                  swr_q;
  logic [DATA_WIDTH-1:0] swdata_q;

  // Register state
  logic [DATA_WIDTH-1:0] outbound_byte;
  logic [DATA_WIDTH-1:0] inbound_byte;
  logic [3:0]            user_hi;
  logic                  user_lo;
  logic                  cmd_flag;
  logic                  input_full_flag;
  logic                  output_full_flag;

  wire logic [DATA_WIDTH-1:0] channel_status =
    {user_hi, cmd_flag, user_lo, input_full_flag, output_full_flag};

  // Host edges, qualified by the select held up to the edge
  wire logic host_wr_rise = rise(wr_n_q, host_write_strobe_n_i) & ~cs_n_q;
  wire logic host_rd_rise = rise(rd_n_q, host_read_strobe_n_i) & ~cs_n_q
                            & ~addr_q;
  // Slave edges; the select is sampled with the strobe
  wire logic slave_rd_fall  = fall(srd_q, slave_read_i)
                              & (ssel_q == SLAVE_DATA);
  wire logic slave_wr_fall  = fall(swr_q, slave_write_i)
                              & (ssel_q == SLAVE_DATA);
  wire logic status_wr_fall = fall(swr_q, slave_write_i)
                              & (ssel_q == SLAVE_STATUS);

  // Fast gate mode: command writes are kept from raising input-full
  wire logic ibf_set   = host_wr_rise                                  // [R6]
                       & ~(fast_a20_enable_i & addr_q);                // [R10]
  wire logic ibf_clear = slave_rd_fall;                                // [R6]
  wire logic obf_set   = slave_wr_fall;                                // [R8]
  wire logic obf_clear = host_rd_rise                                  // [R8]
                       | (status_wr_fall & ~swdata_q[OBF_BIT]);        // [R9]

  // Set wins over clear so a same-cycle event is never lost
  wire logic next_input_full  = ibf_set | (input_full_flag & ~ibf_clear);
  wire logic next_output_full = obf_set | (output_full_flag & ~obf_clear);
  wire logic next_cmd_flag    =
    host_wr_rise ? addr_q : cmd_flag;                                  // [R4] [R5]
  wire logic [3:0] next_user_hi =
    status_wr_fall ? swdata_q[USER_HI_MSB:USER_HI_LSB] : user_hi;      // [R3]
  wire logic next_user_lo =
    status_wr_fall ? swdata_q[USER_LO_BIT] : user_lo;                  // [R3]

  // Host read path; registered, so the bus follows the pins by one cycle
  wire logic next_host_oe =
    ~channel_select_n_i & ~host_read_strobe_n_i;                       // [R1]
  wire logic [DATA_WIDTH-1:0] next_host_data =
    host_address_line_i ? channel_status : outbound_byte; // [R1] [R13]
  wire logic [DATA_WIDTH-1:0] next_slave_rdata =
    (slave_select_i == SLAVE_STATUS) ? channel_status : inbound_byte;
  wire logic next_irq =
    input_full_flag & input_full_irq_enable_i;                         // [R7] [R12]

  always_ff @(posedge clock_i)
  begin
    cs_n_q   <= channel_select_n_i;
    addr_q   <= host_address_line_i;
    rd_n_q   <= host_read_strobe_n_i;
    wr_n_q   <= host_write_strobe_n_i;
    hdata_q  <= host_data_i;
    ssel_q   <= slave_select_i;
    srd_q    <= slave_read_i;
    swr_q    <= slave_write_i;
    swdata_q <= slave_wdata_i;
    if (!resetn_i)
    begin
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      srd_q  <= 1'b0;
      swr_q  <= 1'b0;
    end
  end

  // Data registers carry no reset value
  always_ff @(posedge clock_i)
  begin
    if (slave_wr_fall)
      outbound_byte <= swdata_q;                                       // [R2]
    if (host_wr_rise)
      inbound_byte <= hdata_q;                                         // [R11]
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      user_hi          <= USER_HI_RESET;
      user_lo          <= FLAG_RESET;
      cmd_flag         <= FLAG_RESET;
      input_full_flag  <= FLAG_RESET;
      output_full_flag <= FLAG_RESET;
    end
    else
    begin
      user_hi          <= next_user_hi;
      user_lo          <= next_user_lo;
      cmd_flag         <= next_cmd_flag;
      input_full_flag  <= next_input_full;
      output_full_flag <= next_output_full;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      host_data_o      <= '0;
      host_data_oe_o   <= 1'b0;
      slave_rdata_o    <= '0;
      input_full_irq_o <= 1'b0;
    end
    else
    begin
      host_data_o      <= next_host_data;
      host_data_oe_o   <= next_host_oe;
      slave_rdata_o    <= next_slave_rdata;
      input_full_irq_o <= next_irq;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  host_drive_a : assert property ( // [R1]
    host_data_oe_o |-> $past(~channel_select_n_i & ~host_read_strobe_n_i))
    else $error("host bus driven without select and read strobe");

  data_read_a : assert property ( // [R1]
    ~channel_select_n_i & ~host_read_strobe_n_i & ~host_address_line_i
    |=> host_data_oe_o && host_data_o == $past(outbound_byte))
    else $error("host data read did not return outbound byte");

  status_read_a : assert property ( // [R13]
    ~channel_select_n_i & ~host_read_strobe_n_i & host_address_line_i
    |=> host_data_oe_o && host_data_o == $past(channel_status))
    else $error("host status read did not return status");

  user_bits_a : assert property ( // [R3]
    status_wr_fall |=> user_hi == $past(swdata_q[USER_HI_MSB:USER_HI_LSB])
                       && user_lo == $past(swdata_q[USER_LO_BIT]))
    else $error("user status bits not written");

  cmd_track_a : assert property ( // [R5]
    host_wr_rise |=> cmd_flag == $past(addr_q))
    else $error("command flag does not follow address line");

  inbound_cap_a : assert property ( // [R11]
    host_wr_rise |=> inbound_byte == $past(hdata_q))
    else $error("inbound byte not captured");

  ibf_set_a : assert property ( // [R6]
    host_wr_rise & ~fast_a20_enable_i |=> input_full_flag)
    else $error("input full not set by host write");

  ibf_clear_a : assert property ( // [R6]
    slave_rd_fall & ~ibf_set |=> ~input_full_flag)
    else $error("input full not cleared by slave read");

  ibf_fast_a : assert property ( // [R10]
    ~input_full_flag & host_wr_rise & fast_a20_enable_i & addr_q
    |=> ~input_full_flag)
    else $error("fast gate command write raised input full");

  obf_set_a : assert property ( // [R8]
    slave_wr_fall |=> output_full_flag
                      && outbound_byte == $past(swdata_q))
    else $error("output full not set by slave write");

  obf_clear_a : assert property ( // [R8]
    host_rd_rise & ~obf_set |=> ~output_full_flag)
    else $error("output full not cleared by host read");

  obf_write_a : assert property ( // [R9]
    status_wr_fall & ~obf_set & ~host_rd_rise
    |=> output_full_flag
        == ($past(output_full_flag) & $past(swdata_q[OBF_BIT])))
    else $error("output full slave write misbehaved");

  irq_gate_a : assert property ( // [R12]
    input_full_flag & input_full_irq_enable_i |=> input_full_irq_o)
    else $error("enabled input full request not raised");

  irq_mask_a : assert property ( // [R7]
    input_full_irq_o |-> $past(input_full_flag & input_full_irq_enable_i))
    else $error("interrupt request without enabled input full");

  reset_clear_a : assert property ( // [R3]
    disable iff (1'b0)
    !resetn_i |=> channel_status == {USER_HI_RESET, {4{FLAG_RESET}}})
    else $error("status not cleared by reset");

  user_hold_a : assert property ( // [R3]
    ~status_wr_fall
    |=> $stable(user_hi) && $stable(user_lo))
    else $error("user bits changed without slave write");

  cmd_hold_a : assert property ( // [R4]
    ~host_wr_rise
    |=> $stable(cmd_flag))
    else $error("command flag changed without host write");

  ibf_hold_a : assert property ( // [R7]
    ~host_wr_rise & ~slave_rd_fall
    |=> $stable(input_full_flag))
    else $error("input full changed without its events");

  obf_hold_a : assert property ( // [R8]
    ~slave_wr_fall & ~host_rd_rise & ~status_wr_fall
    |=> $stable(output_full_flag))
    else $error("output full changed without its events");

  oe_idle_a : assert property ( // [R1]
    channel_select_n_i | host_read_strobe_n_i
    |=> ~host_data_oe_o)
    else $error("host bus driven while not selected for read");

  slave_status_a : assert property ( // [R3]
    slave_select_i == SLAVE_STATUS
    |=> slave_rdata_o == $past(channel_status))
    else $error("slave status read returned wrong value");

  slave_data_a : assert property ( // [R11]
    slave_read_i & (slave_select_i == SLAVE_DATA)
    |=> slave_rdata_o == $past(inbound_byte))
    else $error("slave data read returned wrong value");

  irq_block_a : assert property ( // [R12]
    ~input_full_irq_enable_i
    |=> ~input_full_irq_o)
    else $error("masked input full request raised");

  fast_data_a : assert property ( // [R10]
    host_wr_rise & fast_a20_enable_i & ~addr_q
    |=> input_full_flag)
    else $error("fast gate data write did not set input full");

  outbound_keep_a : assert property ( // [R2]
    output_full_flag & ~slave_wr_fall
    |=> $stable(outbound_byte))
    else $error("outbound byte changed without slave write");

  inbound_keep_a : assert property ( // [R11]
    input_full_flag & ~host_wr_rise
    |=> $stable(inbound_byte))
    else $error("inbound byte changed without host write");

endmodule
`default_nettype wire

// ==== hdl/host_port_pkg.sv ====
// Constants shared by the host port data and status channel
`default_nettype none
package host_port_pkg;
  localparam int unsigned DATA_WIDTH   = 8;
  // Slave-side register select values
  localparam logic        SLAVE_DATA   = 1'b0;
  localparam logic        SLAVE_STATUS = 1'b1;
  // Status field positions
  localparam int unsigned USER_HI_MSB  = 7;
  localparam int unsigned USER_HI_LSB  = 4;
  localparam int unsigned CMD_BIT      = 3;
  localparam int unsigned USER_LO_BIT  = 2;
  localparam int unsigned IBF_BIT      = 1;
  localparam int unsigned OBF_BIT      = 0;
  // Reset values
  localparam logic [3:0]  USER_HI_RESET = 4'h0;
  localparam logic        FLAG_RESET    = 1'b0;
endpackage
`default_nettype wire

// ==== verif/host_cpu_model.sv ====
// Behavioural host processor driving one channel of the parallel host bus
`default_nettype none
module host_cpu_model
  import host_port_pkg::*;
(
  // Clock
  input  wire logic                  clock_i,
  // Read return from the channel
  input  wire logic [DATA_WIDTH-1:0] read_data_i,
  input  wire logic                  read_oe_i,
  // Host bus
  output logic                       select_n_o,
  output logic                       address_o,
  output logic                       read_n_o,
  output logic                       write_n_o,
  output logic      [DATA_WIDTH-1:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    select_n_o = 1'b1;
    address_o  = 1'b0;
    read_n_o   = 1'b1;
    write_n_o  = 1'b1;
    data_o     = 8'h00;
  end
  // Data and address stay put through the strobe's rising edge
  task automatic write_byte(input logic a, input logic [7:0] d);
    @(posedge clock_i) #1;
    select_n_o = 1'b0;
    address_o  = a;
    data_o     = d;
    write_n_o  = 1'b0;
    @(posedge clock_i) #1;
    write_n_o  = 1'b1;
    @(posedge clock_i) #1;
    select_n_o = 1'b1;
    // A released bus must not keep showing the written byte
    data_o     = ~d;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic read_byte(input logic a, output logic [7:0] d,
                           output logic oe);
    @(posedge clock_i) #1;
    select_n_o = 1'b0;
    address_o  = a;
    read_n_o   = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    d          = read_data_i;
    oe         = read_oe_i;
    read_n_o   = 1'b1;
    @(posedge clock_i) #1;
    select_n_o = 1'b1;
    repeat (2) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

// ==== verif/test_host_port_channel.sv ====
// Self-checking bench for one host port channel
`default_nettype none
module test_host_port_channel
  import host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       cs_n, addr, rd_n, wr_n, oe, irq;
  logic       ssel = 1'b0, srd = 1'b0, swr = 1'b0;
  logic       fast = 1'b0, irq_en = 1'b1;
  logic [7:0] hd_in, hd_out, swd = 8'h00, srdata, d;
  int         n_errors = 0;
  int         comparisons = 0;
  initial
    forever #4 clock_i = ~clock_i;
  host_cpu_model i_host (.clock_i(clock_i), .read_data_i(hd_out),
    .read_oe_i(oe), .select_n_o(cs_n), .address_o(addr),
    .read_n_o(rd_n), .write_n_o(wr_n), .data_o(hd_in));
  host_port_channel i_dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .channel_select_n_i(cs_n), .host_address_line_i(addr),
    .host_read_strobe_n_i(rd_n), .host_write_strobe_n_i(wr_n),
    .host_data_i(hd_in), .host_data_o(hd_out), .host_data_oe_o(oe),
    .slave_select_i(ssel), .slave_read_i(srd), .slave_write_i(swr),
    .slave_wdata_i(swd), .slave_rdata_o(srdata),
    .fast_a20_enable_i(fast), .input_full_irq_enable_i(irq_en),
    .input_full_irq_o(irq));
  task automatic check(input string what, input logic [7:0] e,
                       input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic slave_access(input logic s, input logic w,
                              input logic [7:0] wd);
    @(posedge clock_i) #1;
    ssel = s;
    swd  = wd;
    swr  = w;
    srd  = ~w;
    @(posedge clock_i) #1;
    d    = srdata;
    swr  = 1'b0;
    srd  = 1'b0;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic status_is(input logic [7:0] e, input logic i);
    slave_access(SLAVE_STATUS, 1'b0, 8'h00);
    check("channel_status", e, d);
    check("input_full_irq", {7'h00, i}, {7'h00, irq});
  endtask
  task automatic data_write_irq();
    status_is(8'h00, 1'b0);
    i_host.write_byte(1'b0, 8'hA5);
    status_is(8'h02, 1'b1);
    slave_access(SLAVE_DATA, 1'b0, 8'h00);
    check("inbound_byte", 8'hA5, d);
    status_is(8'h00, 1'b0);
  endtask
  task automatic command_masked();
    @(posedge clock_i) #1 irq_en = 1'b0;
    i_host.write_byte(1'b1, 8'h5A);
    status_is(8'h0A, 1'b0);
    slave_access(SLAVE_DATA, 1'b0, 8'h00);
    check("inbound_byte", 8'h5A, d);
    status_is(8'h08, 1'b0);
    @(posedge clock_i) #1 irq_en = 1'b1;
  endtask
  task automatic fast_gate();
    @(posedge clock_i) #1 fast = 1'b1;
    i_host.write_byte(1'b0, 8'h22);
    status_is(8'h02, 1'b1);
    slave_access(SLAVE_DATA, 1'b0, 8'h00);
    check("inbound_byte", 8'h22, d);
    i_host.write_byte(1'b1, 8'h11);
    status_is(8'h08, 1'b0);
    @(posedge clock_i) #1 fast = 1'b0;
  endtask
  task automatic reset_clears();
    slave_access(SLAVE_STATUS, 1'b1, 8'hF4);
    i_host.write_byte(1'b1, 8'h33);
    status_is(8'hFE, 1'b1);
    @(posedge clock_i) #1 resetn_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    @(posedge clock_i);
    status_is(8'h00, 1'b0);
  endtask
  task automatic outbound_path();
    logic o;
    slave_access(SLAVE_DATA, 1'b1, 8'h3C);
    status_is(8'h09, 1'b0);
    slave_access(SLAVE_STATUS, 1'b1, 8'hF5);
    status_is(8'hFD, 1'b0);
    i_host.read_byte(1'b1, d, o);
    check("host status", 8'hFD, d);
    i_host.read_byte(1'b0, d, o);
    check("outbound_byte", 8'h3C, d);
    check("host_data_oe", 8'h01, {7'h00, o});
    check("idle oe", 8'h00, {7'h00, oe});
    status_is(8'hFC, 1'b0);
    slave_access(SLAVE_DATA, 1'b1, 8'h77);
    slave_access(SLAVE_STATUS, 1'b1, 8'h02);
    status_is(8'h08, 1'b0);
  endtask
  task automatic complete_run();
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clock_i);
    #1 resetn_i = 1'b1;
    @(posedge clock_i);
    data_write_irq();
    command_masked();
    fast_gate();
    outbound_path();
    reset_clears();
    complete_run();
  end
  initial
  begin
    #20000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
